// ==== design/mbc_pkg.sv ====
package mbc_pkg;
  // ==========================================================
  // Register map (word index = byte address / 4)
  localparam logic [7:0] ADDR_GMR    = 8'h00;
  localparam logic [7:0] ADDR_MEMORY_STATUS_REGISTER  = 8'h01;
  localparam logic [7:0] ADDR_PINASG = 8'h02;
  localparam logic [7:0] ADDR_STRAP  = 8'h03;
  localparam logic [7:0] ADDR_BASE0  = 8'h10;
  localparam logic [7:0] ADDR_OPT0   = 8'h18;
  localparam int         NBANK       = 8;
  // ==========================================================
  // Global config fields
  localparam int GMR_REFRESH_COUNT_FIELD_LSB = 24;
  localparam int GMR_REFRESH_ENABLE_BIT      = 23;
  localparam int GMR_REFRESH_CYCLE_LENGTH_LSB  = 21;
  localparam int GMR_PGS_LSB   = 18;
  localparam int GMR_DWQ       = 17;
  localparam int GMR_PARITY_BUS_ERROR_ENABLE      = 16;
  localparam int GMR_INTERNAL_ADDR_MUX_ENABLE      = 15;
  localparam logic [31:0] GMR_RST = 32'h0000_0000;
  // ==========================================================
  // Base register fields
  localparam int BR_BA_LSB  = 11;
  localparam int BR_FC_LSB  = 7;
  localparam int BR_BANK_PARITY_ENABLE   = 3;
  localparam int BR_WP      = 1;
  localparam int BR_V       = 0;
  // ==========================================================
  // Option register fields
  localparam int OR_CYCLE_LENGTH_FIELD_LSB = 28;
  localparam int OR_AM_LSB   = 11;
  localparam int OR_FCM_LSB  = 7;
  localparam int OR_PAGE_MODE_ENABLE     = 3;
  localparam int OR_SPS_LSB  = 1;
  localparam int OR_DRAM_SELECT_BIT    = 0;
  localparam logic [1:0] SPS_32 = 2'h0;
  localparam logic [1:0] SPS_16 = 2'h1;
  localparam logic [1:0] SPS_8  = 2'h2;
  // ==========================================================
  // Reset values
  localparam logic [31:0] BR0_RST    = 32'h0000_0001;
  localparam logic [31:0] OR0_RST    = 32'hF000_0000;
  localparam logic [15:0] PINASG_RST = 16'h0000;
  localparam logic [15:0] PINASG_STD = 16'h0180;
  localparam logic [2:0]  STRAP_STD  = 3'h7;
  localparam logic [3:0]  FC_CPU     = 4'h7;
  // ==========================================================
  // Timing
  localparam int  CLK_MHZ       = 125;
  localparam int  REF_PRESCALE  = 16;
  localparam int  REF_NS_X10    = 156 * 100;
  localparam int  DRAM_INIT_CNT = 8;
  localparam logic [3:0] RAS_SETUP = 4'h1;
  typedef enum logic [2:0] {
    MBC_IDLE, MBC_ROW, MBC_DATA, MBC_WAIT, MBC_NEXT, MBC_REF
  } mbc_state_type;
endpackage

// ==== design/mbc_memory_bank_controller.sv ====
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - Strap 111 enables core, byte boot port
// - Refresh interval from programmable count field
// - Refresh cycle length field sets duration
// - Page size field selects page-mode detection
// - Parity error with enable ends in bus error
// - Parity errors recorded in status register
// - Per-bank base address compared to bus
// - Per-bank write protect bit
// - Access bank select only when valid bit set; refresh selects every DRAM bank
// - Per-bank byte parity generate and check
// - Per-bank wait states every access
// - Address mask sets bank block size
// - Zero function mask excludes CPU space
// - Port size; wide transfers split up
// - DRAM select bit gives row strobe
// - Page mode enable on DRAM bank
// - Reset on parity line 3 selects 16-bit
// - Pin value 0180 enables strobe functions
// - Double drive duplicates row strobe one
// - Eight reads or refresh cycles before first DRAM write
// - Internal row/column mux; pin becomes OE
module mbc_memory_bank_controller (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Avalon-MM register slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Processor access port
  input  wire logic        cpu_req,
  input  wire logic        cpu_wr,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [3:0]  cpu_fc,
  input  wire logic [3:0]  cpu_be,
  input  wire logic [31:0] cpu_wdata,
  output logic [31:0]      cpu_rdata,
  output logic             cpu_ack,
  output logic             cpu_berr,
  // Straps and pins
  input  wire logic [2:0]  config_strap_pins,
  input  wire logic        parity_line_3_in,
  output logic             core_enable,
  output logic             module_base_register_normal,
  // Memory side
  output logic [27:0]      mem_addr,
  output logic [31:0]      mem_dout,
  output logic             mem_doe,
  input  wire logic [31:0] mem_din,
  output logic [3:0]       par_out,
  output logic             par_oe,
  input  wire logic [3:0]  par_in,
  output logic [7:0]       bank_sel_n,
  output logic             row_strobe_one_double_drive_n,
  output logic [3:0]       column_strobes_n,
  output logic [3:0]       byte_write_enables_n,
  output logic             mem_oe_n
);
  // ==========================================================
  // Registers
  logic [31:0] gmr_r;
  logic [31:0] br_r [mbc_pkg::NBANK];
  logic [31:0] or_r [mbc_pkg::NBANK];
  logic [3:0]  memory_status_register_r;
  logic [15:0] pinasg_r;
  logic [2:0]  strap_s1_r, strap_s2_r, strap_s3_r;
  logic        p3_s1_r, p3_s2_r, p3_s3_r;
  logic [2:0]  strap_r;
  logic        bus16_r;
  logic        latch_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  mbc_pkg::mbc_state_type state_r;
  logic [15:0] pre_r;
  logic [7:0]  refcnt_r;
  logic        ref_pend_r;
  logic [3:0]  init_reads_r;
  logic [4:0]  wcnt_r;
  logic [2:0]  bank_r;
  logic [1:0]  beat_r;
  logic [31:0] page_r;
  logic        page_vld_r;
  logic [31:0] acc_r;
  logic        sel_act_r;
  logic        berr_r, done_r;
  logic [3:0]  perr_r;
  // ==========================================================
  // Straps: three-stage sampling, captured after reset release
  always_ff @(posedge sys_clk) begin
    strap_s1_r <= config_strap_pins;
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
    p3_s1_r    <= parity_line_3_in;
    p3_s2_r    <= p3_s1_r;
    p3_s3_r    <= p3_s2_r;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_r <= 1'b1;
      strap_r <= mbc_pkg::STRAP_STD;
      bus16_r <= 1'b0;
    end else if (latch_r && strap_s2_r == strap_s3_r) begin
      latch_r <= 1'b0;
      strap_r <= strap_s3_r;
      bus16_r <= p3_s3_r;
    end
  end
  wire strap_std = (strap_r == mbc_pkg::STRAP_STD);
  assign core_enable = strap_std;
  assign module_base_register_normal = strap_std;
  // ==========================================================
  // Global field decode
  wire [7:0]  refresh_count_field   = gmr_r[mbc_pkg::GMR_REFRESH_COUNT_FIELD_LSB +: 8];
  wire        refresh_enable_bit    = gmr_r[mbc_pkg::GMR_REFRESH_ENABLE_BIT];
  wire [1:0]  refresh_cycle_length    = gmr_r[mbc_pkg::GMR_REFRESH_CYCLE_LENGTH_LSB +: 2];
  wire [2:0]  pgs     = gmr_r[mbc_pkg::GMR_PGS_LSB +: 3];
  wire        parity_bus_error_enable    = gmr_r[mbc_pkg::GMR_PARITY_BUS_ERROR_ENABLE];
  wire        internal_addr_mux_enable    = gmr_r[mbc_pkg::GMR_INTERNAL_ADDR_MUX_ENABLE];
  wire        dram_wait_qualifier     = gmr_r[mbc_pkg::GMR_DWQ];
  wire [4:0]  pg_bits = 5'd9 + {2'h0, pgs};
  wire [31:0] pg_mask = ~((32'h1 << pg_bits) - 32'h1);
  // ==========================================================
  // Bank match, one hot by priority
  logic [7:0] hit;
  genvar g;
  generate
    for (g = 0; g < mbc_pkg::NBANK; g++) begin : g_bank
      wire [20:0] ba   = br_r[g][31:mbc_pkg::BR_BA_LSB];
      wire [16:0] am   = or_r[g][27:mbc_pkg::OR_AM_LSB];
      wire [3:0]  fcm  = or_r[g][mbc_pkg::OR_FCM_LSB +: 4];
      wire [3:0]  fcb  = br_r[g][mbc_pkg::BR_FC_LSB +: 4];
      wire [20:0] msk  = {4'hF, am};
      wire        amat = ((cpu_addr[31:11] ^ ba) & msk) == 21'h0;
      wire        fok  = (fcm == 4'h0) ? (cpu_fc != mbc_pkg::FC_CPU)
                                       : (((cpu_fc ^ fcb) & ~fcm) == 4'h0);
      assign hit[g] = amat & fok & br_r[g][mbc_pkg::BR_V];
    end
  endgenerate
  wire [7:0] hit1 = hit & ~(hit - 8'h1);
  logic [2:0] hit_idx;
  always_comb begin
    hit_idx = 3'h0;
    for (int i = mbc_pkg::NBANK - 1; i >= 0; i--) begin
      if (hit1[i]) hit_idx = 3'(i);
    end
  end
  // ==========================================================
  // Active bank decode
  wire [31:0] cur_or   = or_r[bank_r];
  wire [31:0] cur_br   = br_r[bank_r];
  wire        is_dram  = cur_or[mbc_pkg::OR_DRAM_SELECT_BIT];
  wire        page_mode_enable     = cur_or[mbc_pkg::OR_PAGE_MODE_ENABLE] & is_dram;
  wire [1:0]  sps      = cur_or[mbc_pkg::OR_SPS_LSB +: 2];
  wire [3:0]  cycle_length_field     = cur_or[mbc_pkg::OR_CYCLE_LENGTH_FIELD_LSB +: 4];
  wire        bank_parity_enable    = cur_br[mbc_pkg::BR_BANK_PARITY_ENABLE];
  wire        wprot    = cur_br[mbc_pkg::BR_WP];
  wire [1:0]  nbeats   = (sps == mbc_pkg::SPS_8) ? 2'h3 :
                         (sps == mbc_pkg::SPS_16 || bus16_r) ? 2'h1 : 2'h0;
  wire        page_hit = page_vld_r && page_mode_enable &&
                         ((cpu_addr & pg_mask) == (page_r & pg_mask));
  wire        init_ok  = (init_reads_r == 4'(mbc_pkg::DRAM_INIT_CNT));
  // Lane of the current beat
  wire [1:0]  lane     = (nbeats == 2'h3) ? beat_r :
                         (nbeats == 2'h1) ? {beat_r[0], 1'b0} : 2'h0;
  wire [3:0]  beat_be  = (nbeats == 2'h3) ? 4'h8 :
                         (nbeats == 2'h1) ? 4'hC : 4'hF;
  wire [3:0]  act_be   = beat_be & 4'(cpu_be << lane);
  wire [3:0]  cpu_act  = act_be >> lane;
  wire [31:0] wdata_sh = cpu_wdata << {lane, 3'h0};
  wire [31:0] beat_data = (nbeats == 2'h0) ? mem_din : (mem_din >> {lane, 3'h0});
  // Byte parity generate and check
  logic [3:0] par_gen, par_bad;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      par_gen[b] = ~^wdata_sh[b*8 +: 8];
      par_bad[b] = (^mem_din[b*8 +: 8]) == par_in[b];
    end
  end
  wire [3:0] par_lanes = bus16_r ? 4'hC : 4'hF;
  wire [3:0] perr_now  = par_bad & par_lanes & act_be & {4{bank_parity_enable}};
  // ==========================================================
  // Refresh timer
  wire ref_tick = refresh_enable_bit && pre_r == 16'(mbc_pkg::REF_PRESCALE - 1) && refcnt_r == 8'h0;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_r    <= 16'h0;
      refcnt_r <= 8'h0;
    end else if (!refresh_enable_bit) begin
      pre_r    <= 16'h0;
      refcnt_r <= refresh_count_field;
    end else if (pre_r == 16'(mbc_pkg::REF_PRESCALE - 1)) begin
      pre_r    <= 16'h0;
      refcnt_r <= (refcnt_r == 8'h0) ? refresh_count_field : refcnt_r - 8'h1;
    end else begin
      pre_r <= pre_r + 16'h1;
    end
  end
  // ==========================================================
  // Access state machine
  wire cpu_go = cpu_req && !done_r && !ack_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r      <= mbc_pkg::MBC_IDLE;
      ref_pend_r   <= 1'b0;
      init_reads_r <= 4'h0;
      wcnt_r       <= 5'h0;
      bank_r       <= 3'h0;
      beat_r       <= 2'h0;
      page_r       <= 32'h0;
      page_vld_r   <= 1'b0;
      acc_r        <= 32'h0;
      sel_act_r    <= 1'b0;
      berr_r       <= 1'b0;
      done_r       <= 1'b0;
      perr_r       <= 4'h0;
    end else begin
      perr_r <= 4'h0;
      if (ref_tick) ref_pend_r <= 1'b1;
      if (done_r && !cpu_req) done_r <= 1'b0;
      case (state_r)
        mbc_pkg::MBC_IDLE: begin
          sel_act_r <= 1'b0;
          if (ref_pend_r) begin
            ref_pend_r <= 1'b1 & ref_tick;
            page_vld_r <= 1'b0;
            wcnt_r     <= {3'h0, refresh_cycle_length} + 5'h2;
            state_r    <= mbc_pkg::MBC_REF;
          end else if (cpu_go && hit1 != 8'h0) begin
            bank_r    <= hit_idx;
            beat_r    <= 2'h0;
            acc_r     <= 32'h0;
            sel_act_r <= 1'b1;
            state_r   <= mbc_pkg::MBC_ROW;
          end else if (cpu_go) begin
            berr_r  <= 1'b1;
            done_r  <= 1'b1;
          end
        end
        mbc_pkg::MBC_ROW: begin
          if ((cpu_wr && wprot) ||
              (cpu_wr && is_dram && !init_ok)) begin
            berr_r    <= 1'b1;
            done_r    <= 1'b1;
            sel_act_r <= 1'b0;
            state_r   <= mbc_pkg::MBC_IDLE;
          end else begin
            wcnt_r  <= (page_hit ? 5'h0 : {1'b0, mbc_pkg::RAS_SETUP}) + {1'b0, cycle_length_field}
                       + {4'h0, dram_wait_qualifier & page_mode_enable};
            state_r <= mbc_pkg::MBC_DATA;
          end
        end
        mbc_pkg::MBC_DATA: begin
          if (wcnt_r != 5'h0) begin
            wcnt_r <= wcnt_r - 5'h1;
          end else begin
            state_r <= mbc_pkg::MBC_NEXT;
          end
        end
        mbc_pkg::MBC_NEXT: begin
          for (int b = 0; b < 4; b++) begin
            if (cpu_act[b]) acc_r[b*8 +: 8] <= beat_data[b*8 +: 8];
          end
          perr_r <= cpu_wr ? 4'h0 : perr_now;
          if (!cpu_wr && is_dram && !init_ok) init_reads_r <= init_reads_r + 4'h1;
          if (!cpu_wr && parity_bus_error_enable && perr_now != 4'h0) begin
            berr_r <= 1'b1;
          end
          if (beat_r == nbeats) begin
            done_r     <= 1'b1;
            sel_act_r  <= page_mode_enable;
            page_r     <= cpu_addr;
            page_vld_r <= page_mode_enable;
            state_r    <= mbc_pkg::MBC_IDLE;
          end else begin
            beat_r  <= beat_r + 2'h1;
            wcnt_r  <= {1'b0, cycle_length_field};
            state_r <= mbc_pkg::MBC_DATA;
          end
        end
        mbc_pkg::MBC_REF: begin
          if (wcnt_r != 5'h0) begin
            wcnt_r <= wcnt_r - 5'h1;
          end else begin
            if (!init_ok) init_reads_r <= init_reads_r + 4'h1;
            state_r <= mbc_pkg::MBC_IDLE;
          end
        end
        default: state_r <= mbc_pkg::MBC_IDLE;
      endcase
      if (ack_r) berr_r <= 1'b0;
    end
  end
  // ==========================================================
  // CPU answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_r     <= 1'b0;
      cpu_rdata <= 32'h0;
    end else begin
      ack_r <= done_r && !ack_r && cpu_req && !(state_r == mbc_pkg::MBC_IDLE && ack_r);
      if (done_r && !ack_r) cpu_rdata <= acc_r;
    end
  end
  assign cpu_ack  = ack_r;
  assign cpu_berr = ack_r & berr_r;
  // ==========================================================
  // Memory pins
  wire in_acc  = (state_r == mbc_pkg::MBC_DATA || state_r == mbc_pkg::MBC_NEXT);
  wire in_ref  = (state_r == mbc_pkg::MBC_REF);
  wire [3:0] strobe_be = in_acc ? act_be : 4'h0;
  wire [7:0] bank_oh   = 8'h1 << bank_r;
  wire [7:0] dram_mask;
  generate
    for (g = 0; g < mbc_pkg::NBANK; g++) begin : g_dm
      assign dram_mask[g] = or_r[g][mbc_pkg::OR_DRAM_SELECT_BIT];
    end
  endgenerate
  wire [7:0] sel_on  = (sel_act_r ? bank_oh : 8'h0) | (in_ref ? dram_mask : 8'h0);
  wire       wide    = pinasg_r == mbc_pkg::PINASG_STD;
  wire       row_on  = (state_r != mbc_pkg::MBC_ROW) || !is_dram;
  wire [27:0] col_ad = {12'h0, cpu_addr[17:2]};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_addr <= 28'h0;
      mem_dout <= 32'h0;
      par_out  <= 4'h0;
    end else begin
      mem_addr <= (internal_addr_mux_enable && is_dram && row_on) ? col_ad
                : cpu_addr[27:0] + {26'h0, lane};
      mem_dout <= wdata_sh;
      par_out  <= par_gen;
    end
  end
  assign mem_doe   = in_acc & cpu_wr;
  assign par_oe    = in_acc & cpu_wr & bank_parity_enable;
  assign bank_sel_n = ~sel_on;
  assign row_strobe_one_double_drive_n = ~(wide & sel_on[1]);
  assign column_strobes_n = ~(wide ? ((is_dram ? strobe_be : 4'h0) |
                              (in_ref ? 4'hF : 4'h0)) : 4'h0);
  assign byte_write_enables_n = ~(wide && cpu_wr ? strobe_be : 4'h0);
  assign mem_oe_n  = ~(internal_addr_mux_enable & in_acc & ~cpu_wr);
  // ==========================================================
  // Avalon-MM slave, answers one cycle after request
  wire       is_br  = avs_address[7:3] == mbc_pkg::ADDR_BASE0[7:3];
  wire       is_or  = avs_address[7:3] == mbc_pkg::ADDR_OPT0[7:3];
  wire [2:0] ridx   = avs_address[2:0];
  wire [31:0] bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  logic bus_ph_r;
  wire acc_ok = (avs_read | avs_write) & bus_ph_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_ph_r <= 1'b0;
      gmr_r    <= mbc_pkg::GMR_RST;
      pinasg_r <= mbc_pkg::PINASG_RST;
      memory_status_register_r  <= 4'h0;
      rdata_r  <= 32'h0;
      for (int i = 0; i < mbc_pkg::NBANK; i++) begin
        br_r[i] <= (i == 0) ? mbc_pkg::BR0_RST : 32'h0;
        or_r[i] <= (i == 0) ? (mbc_pkg::OR0_RST |
                    {29'h0, mbc_pkg::SPS_8, 1'b0}) : 32'h0;
      end
    end else begin
      bus_ph_r <= (avs_read | avs_write) & ~bus_ph_r;
      if (acc_ok && avs_write) begin
        if (avs_address == mbc_pkg::ADDR_GMR)
          gmr_r <= (gmr_r & ~bemask) | (avs_writedata & bemask);
        if (avs_address == mbc_pkg::ADDR_PINASG)
          pinasg_r <= (pinasg_r & ~bemask[15:0]) | (avs_writedata[15:0] & bemask[15:0]);
        if (is_br)
          br_r[ridx] <= (br_r[ridx] & ~bemask) | (avs_writedata & bemask);
        if (is_or)
          or_r[ridx] <= (or_r[ridx] & ~bemask) | (avs_writedata & bemask);
      end
      // Write-one-to-clear; a new error wins over the clear
      memory_status_register_r <= (memory_status_register_r & ~((acc_ok && avs_write && avs_address == mbc_pkg::ADDR_MEMORY_STATUS_REGISTER)
                 ? avs_writedata[3:0] & bemask[3:0] : 4'h0)) | perr_r;
      if (avs_read && !bus_ph_r) begin
        rdata_r <= (avs_address == mbc_pkg::ADDR_GMR)    ? gmr_r :
                   (avs_address == mbc_pkg::ADDR_MEMORY_STATUS_REGISTER)  ? {28'h0, memory_status_register_r} :
                   (avs_address == mbc_pkg::ADDR_PINASG) ? {16'h0, pinasg_r} :
                   (avs_address == mbc_pkg::ADDR_STRAP)  ? {27'h0, bus16_r, init_ok, strap_r} :
                   is_br ? br_r[ridx] : is_or ? or_r[ridx] : 32'h0;
      end
    end
  end
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ph_r;
endmodule

// ==== tb/mbc_props.sv ====
`timescale 1ns/100ps
module mbc_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Register bus
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // Processor port
  input wire logic       cpu_req,
  input wire logic       cpu_ack,
  input wire logic       cpu_berr,
  // Straps
  input wire logic [2:0] config_strap_pins,
  input wire logic       core_enable,
  input wire logic       module_base_register_normal,
  // Memory side
  input wire logic [7:0] bank_sel_n,
  input wire logic       row_strobe_one_double_drive_n,
  input wire logic [3:0] byte_write_enables_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Properties
  chk_ack_one_cycle: assert property (cpu_ack |=> !cpu_ack)
    else $error("ack held past one cycle");
  chk_berr_with_ack: assert property (cpu_berr |-> cpu_ack)
    else $error("bus error without ack");
  chk_ack_needs_req: assert property (cpu_ack |-> cpu_req)
    else $error("ack without request");
  chk_wait_first: assert property (
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait in first request cycle");
  chk_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  chk_strap_decode: assert property (
    (config_strap_pins == 3'h7) [*8] |-> core_enable && module_base_register_normal)
    else $error("strap 111 not decoded");
  chk_double_drive: assert property (
    !row_strobe_one_double_drive_n |-> !bank_sel_n[1])
    else $error("double drive without bank one");
  chk_we_selected: assert property (
    !(&byte_write_enables_n) |-> !(&bank_sel_n))
    else $error("write enable with no bank selected");
endmodule
bind mbc_memory_bank_controller mbc_props u_props (
  .sys_clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .cpu_req, .cpu_ack,
  .cpu_berr, .config_strap_pins, .core_enable, .module_base_register_normal, .bank_sel_n,
  .row_strobe_one_double_drive_n, .byte_write_enables_n);

// ==== tb/mbc_mem_model.sv ====
`timescale 1ns/100ps
module mbc_mem_model (
  // Memory side
  input  wire logic        sys_clk,
  input  wire logic [27:0] mem_addr,
  input  wire logic [31:0] mem_dout,
  input  wire logic        mem_doe,
  input  wire logic [7:0]  bank_sel_n,
  input  wire logic [3:0]  byte_write_enables_n,
  input  wire logic        bad_par,
  output logic [31:0]      mem_din,
  output logic [3:0]       par_in
);
  logic [31:0] mem_r [256] = '{default: 32'h0};
  logic [31:0] last_r = 32'h0;
  wire         drive = !(&bank_sel_n) && !mem_doe;
  wire  [7:0]  idx = mem_addr[9:2];
  // ==========================================================
  // Byte lane writes, released bus shows inverse of last value
  always @(posedge sys_clk) begin
    for (int b = 0; b < 4; b++)
      if (mem_doe && !(&bank_sel_n) && !byte_write_enables_n[b])
        mem_r[idx][8*b +: 8] <= mem_dout[8*b +: 8];
    if (drive)
      last_r <= mem_r[idx];
  end
  assign mem_din = drive ? mem_r[idx] : ~last_r;
  for (genvar b = 0; b < 4; b++) begin : g_par
    assign par_in[b] = ~^mem_din[8*b +: 8] ^ bad_par;
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } mbc_row_type;
  // ==========================================================
  // Signals
  logic        sys_clk = 1'b0, rst = 1'b1, bad_par = 1'b0, p3 = 1'b0;
  logic [7:0]  avs_address = 8'h00, bank_sel_n, sel_prev = 8'hFF;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, av_rd, c_rd;
  logic        cpu_req = 1'b0, cpu_wr = 1'b0, cpu_ack, cpu_berr, c_be;
  logic [31:0] cpu_addr = 32'h0, cpu_wdata = 32'h0, cpu_rdata, mem_dout, mem_din;
  logic [3:0]  cpu_fc = 4'h5, par_out, par_in, cas_n, we_n;
  logic        core_enable, module_base_register_normal, mem_doe, par_oe, dd_n, mem_oe_n;
  logic [27:0] mem_addr;
  int          err_total = 0, compares = 0, cyc = 0, c_lat, l0, s5;
  int          sel_cnt [8] = '{default: 0}, c_sel [8];
  localparam mbc_row_type rows [20] = '{
    '{0, 8'h00, 0, mbc_pkg::GMR_RST}, '{0, 8'h10, 0, mbc_pkg::BR0_RST},
    '{0, 8'h18, 0, mbc_pkg::OR0_RST | 32'h0000_0004}, '{0, 8'h02, 0, 32'h0},
    '{1, 8'h00, 32'h0001_8000, 32'h0001_8000}, '{1, 8'h02, 32'hFFFF_0180, 32'h0180},
    '{1, 8'h40, 32'hFFFF_FFFF, 32'h0}, '{1, 8'h03, 32'hFFFF_FFFF, 32'h7},
    '{1, 8'h01, 32'hF, 32'h0}, '{1, 8'h18, 32'h0FFC_0000, 32'h0FFC_0000},
    '{1, 8'h19, 32'h5FF0_0000, 32'h5FF0_0000}, '{1, 8'h1A, 32'h0FF0_0000, 32'h0FF0_0000},
    '{1, 8'h1B, 32'h0FF0_0000, 32'h0FF0_0000}, '{1, 8'h1C, 32'h0FF0_0004, 32'h0FF0_0004},
    '{1, 8'h1D, 32'h0FF0_0001, 32'h0FF0_0001}, '{1, 8'h11, 32'h0010_0001, 32'h0010_0001},
    '{1, 8'h12, 32'h0020_0003, 32'h0020_0003}, '{1, 8'h13, 32'h0030_0009, 32'h0030_0009},
    '{1, 8'h14, 32'h0040_0001, 32'h0040_0001}, '{1, 8'h15, 32'h0050_0001, 32'h0050_0001}};
  // ==========================================================
  // Design and memory
  mbc_memory_bank_controller u_dut (
    .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .cpu_req, .cpu_wr,
    .cpu_addr, .cpu_fc, .cpu_be(4'hF), .cpu_wdata, .cpu_rdata, .cpu_ack, .cpu_berr,
    .config_strap_pins(3'h7), .parity_line_3_in(p3), .core_enable, .module_base_register_normal,
    .mem_addr, .mem_dout, .mem_doe, .mem_din, .par_out, .par_oe, .par_in, .bank_sel_n,
    .row_strobe_one_double_drive_n(dd_n), .column_strobes_n(cas_n),
    .byte_write_enables_n(we_n), .mem_oe_n);
  mbc_mem_model u_mem (.sys_clk, .mem_addr, .mem_dout, .mem_doe, .bank_sel_n,
    .byte_write_enables_n(we_n), .bad_par, .mem_din, .par_in);
  always #4 sys_clk = ~sys_clk;
  // ==========================================================
  // Select edge counts and timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sel_prev <= bank_sel_n;
    for (int i = 0; i < 8; i++)
      if (sel_prev[i] && !bank_sel_n[i])
        sel_cnt[i] <= sel_cnt[i] + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    av_rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task cpu_go(input logic w, input logic [31:0] a, input logic [31:0] d,
              input logic [3:0] f = 4'h5);
    int s0 [8];
    s0 = sel_cnt;
    c_lat = 0;
    cpu_wr <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_fc <= f;
    cpu_req <= 1'b1;
    do begin
      @(posedge sys_clk);
      c_lat++;
    end while (cpu_ack !== 1'b1);
    c_rd = cpu_rdata;
    c_be = cpu_berr;
    cpu_req <= 1'b0;
    @(posedge sys_clk);
    foreach (c_sel[i]) c_sel[i] = sel_cnt[i] - s0[i];
  endtask
  task close_out();
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) begin
      if (rows[i].w) av(1'b1, rows[i].a, rows[i].d);
      av(1'b0, rows[i].a, 32'h0);
      chk(av_rd, rows[i].e);
    end
    cpu_go(1'b1, 32'h0000_0010, 32'hA55A_0FF0);
    chk(32'(c_be), 32'h0);
    cpu_go(1'b0, 32'h0000_0010, 32'h0);
    l0 = c_lat;
    chk(c_rd, 32'hA55A_0FF0);
    chk(32'(c_sel[0]), 32'h1);
    cpu_go(1'b0, 32'h0010_0010, 32'h0);
    chk(c_rd, 32'hA55A_0FF0);
    chk(32'(c_lat - l0), 32'h5);
    chk(32'(c_sel[1]), 32'h1);
    cpu_go(1'b0, 32'h0040_0010, 32'h0);
    chk(32'(c_lat - l0), 32'h6);
    chk(c_rd, 32'hA5A5_A5A5);
    cpu_go(1'b1, 32'h0020_0010, 32'h0);
    chk(32'(c_be), 32'h1);
    cpu_go(1'b1, 32'h0F00_0000, 32'h0);
    chk(32'(c_be), 32'h1);
    cpu_go(1'b0, 32'h0000_0010, 32'h0, mbc_pkg::FC_CPU);
    chk(32'(c_sel[0]), 32'h0);
    av(1'b1, 8'h11, 32'h0010_0000);
    cpu_go(1'b0, 32'h0010_0010, 32'h0);
    chk(32'(c_sel[1]), 32'h0);
    bad_par <= 1'b1;
    cpu_go(1'b0, 32'h0030_0010, 32'h0);
    chk(32'(c_be), 32'h1);
    av(1'b0, 8'h01, 32'h0);
    chk(av_rd, 32'hF);
    av(1'b1, 8'h01, 32'hF);
    av(1'b0, 8'h01, 32'h0);
    chk(av_rd, 32'h0);
    bad_par <= 1'b0;
    cpu_go(1'b0, 32'h0030_0010, 32'h0);
    chk(32'(c_be), 32'h0);
    cpu_go(1'b1, 32'h0050_0010, 32'h1234_5678);
    chk(32'(c_be), 32'h1);
    av(1'b1, 8'h1D, 32'h0FF0_0009);
    av(1'b1, 8'h00, 32'h0083_8000);
    s5 = sel_cnt[5];
    repeat (160) @(posedge sys_clk);
    chk(32'((sel_cnt[5] - s5) inside {[9:11]}), 32'h1);
    av(1'b0, 8'h03, 32'h0);
    chk(av_rd, 32'hF);
    cpu_go(1'b1, 32'h0050_0010, 32'h1234_5678);
    chk(32'(c_be), 32'h0);
    cpu_go(1'b0, 32'h0050_0010, 32'h0);
    chk(c_rd, 32'h1234_5678);
    p3 <= 1'b1;
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    av(1'b0, 8'h03, 32'h0);
    chk(av_rd, 32'h17);
    cpu_go(1'b0, 32'h0000_0010, 32'h0);
    chk(32'(c_lat), 32'h49);
    chk(c_rd, 32'h1212_1212);
    close_out();
  end
endmodule
